// ===== core/swlm_pkg.sv
// Shared constants and types for the write lane mask block
package swlm_pkg;
    typedef enum logic [1:0] {
        ORG_X8 = 2'h0,
        ORG_X9 = 2'h1,
        ORG_X18 = 2'h2,
        ORG_X36 = 2'h3
    } swlm_org_type;

    // Gray order along idle, read, write
    typedef enum logic [1:0] {
        OP_IDLE = 2'h0,
        OP_READ = 2'h1,
        OP_WRITE = 2'h3
    } swlm_op_type;

    localparam int DATA_W = 36;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int NIB_W = 4;
    localparam int LOC_AW = 4;
    localparam int WORD_AW = 6;
    localparam int DEPTH = 64;
    localparam int PIPE_W = 5;
    localparam int CNT_W = 16;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PEEK_ADDR = 8'h08;
    localparam logic [7:0] REG_PEEK_DATA = 8'h0c;

    // Field positions and reset values
    localparam int CTRL_ORG_LSB = 0;
    localparam int STAT_ACC_LSB = 0;
    localparam int STAT_IGN_LSB = 16;
    localparam swlm_org_type ORG_RESET = ORG_X36;
    localparam logic [WORD_AW-1:0] PEEK_RESET = 6'h00;
endpackage : swlm_pkg

// ===== core/swlm_core.sv
// Write lane mask decoding and burst write storage with AHB-Lite registers
// Notes on behaviour
// - x8: low nibble select stores bits 3..0
// - x8: high nibble alone stores bits 7..4
// - x18: lane 0 bits 8..0, lane 1 17..9
// - x9: one select gates whole 9-bit word
// - x36: all selects low store 36 bits
// - x36: lane 0 alone stores bits 8..0
// - x36: lanes 1..3 gate their own bytes
// - x8/x18: both selects high write nothing
// - x9/x36: all selects high suppress write
// - Mask evaluated independently on every data beat
// - Selects matter only in started write beats
// - Four words at t+1 and t+2 edges
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
module swlm_core (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEnable,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Memory port, one beat per core_clk edge
    input wire logic write_port_select_n,
    input wire logic read_port_select_n,
    input wire logic [swlm_pkg::LOC_AW-1:0] burstAddr,
    input wire logic [swlm_pkg::DATA_W-1:0] writeData,
    input wire logic lane0_write_select_n,
    input wire logic lane1_write_select_n,
    input wire logic lane2_write_select_n,
    input wire logic lane3_write_select_n,
    input wire logic low_nibble_write_select_n,
    input wire logic high_nibble_write_select_n,
    // Beat phase seen by the controller
    output logic trueEdge
);
    swlm_pkg::swlm_org_type org;
    swlm_pkg::swlm_org_type next_org;
    swlm_pkg::swlm_op_type opState;
    swlm_pkg::swlm_op_type next_opState;
    logic [swlm_pkg::PIPE_W-1:0] startPipe;
    logic [swlm_pkg::LOC_AW-1:0] pendLoc;
    logic [swlm_pkg::LOC_AW-1:0] activeLoc;
    logic [swlm_pkg::CNT_W-1:0] accCount;
    logic [swlm_pkg::CNT_W-1:0] ignCount;
    logic [swlm_pkg::WORD_AW-1:0] peekAddr;
    logic [swlm_pkg::WORD_AW-1:0] next_peekAddr;
    logic [swlm_pkg::DATA_W-1:0] wordMem [0:swlm_pkg::DEPTH-1];
    logic dataPhaseWrite;
    logic [7:0] dataPhaseOffset;
    logic [31:0] readMux;

    // Even beats are true-clock edges, odd beats complement edges
    always_ff @(posedge core_clk) begin
        if (rst) begin
            trueEdge <= 1'b1;
        end else if (clkEnable) begin
            trueEdge <= ~trueEdge;
        end
    end

    // Port selects are only looked at on true-clock edges
    wire wrReq = trueEdge && !write_port_select_n;
    wire rdReq = trueEdge && !read_port_select_n;
    wire readWins = rdReq && (opState != swlm_pkg::OP_READ);
    wire wrStart = wrReq && (opState != swlm_pkg::OP_WRITE) && !readWins;
    wire wrIgnored = wrReq && !wrStart;

    always_comb begin
        case (opState)
            swlm_pkg::OP_IDLE,
            swlm_pkg::OP_READ,
            swlm_pkg::OP_WRITE: begin
                if (readWins) begin
                    next_opState = swlm_pkg::OP_READ;
                end else if (wrStart) begin
                    next_opState = swlm_pkg::OP_WRITE;
                end else begin
                    next_opState = swlm_pkg::OP_IDLE;
                end
            end
            default: begin
                next_opState = swlm_pkg::OP_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            opState <= swlm_pkg::OP_IDLE;
        end else if (clkEnable && trueEdge) begin
            opState <= next_opState;
        end
    end

    // Data beats follow a start by two beats: t+1 true/comp, t+2 true/comp
    always_ff @(posedge core_clk) begin
        if (rst) begin
            startPipe <= '0;
            pendLoc <= '0;
            activeLoc <= '0;
        end else if (clkEnable) begin
            startPipe <= {startPipe[swlm_pkg::PIPE_W-2:0], wrStart};
            if (wrStart) begin
                pendLoc <= burstAddr;
            end
            // Starts are at least four beats apart, so one slot suffices
            if (startPipe[0]) begin
                activeLoc <= pendLoc;
            end
        end
    end

    wire writeBeat = |startPipe[swlm_pkg::PIPE_W-1:1];
    wire [1:0] beatIdx = startPipe[1] ? 2'h0 : startPipe[2] ? 2'h1 : startPipe[3] ? 2'h2 : 2'h3;
    wire [swlm_pkg::WORD_AW-1:0] wordAddr = {activeLoc, beatIdx};

    // Lane selects of the present beat only
    wire [swlm_pkg::LANES-1:0] laneSel = ~{lane3_write_select_n, lane2_write_select_n,
        lane1_write_select_n, lane0_write_select_n};
    wire lowNib = !low_nibble_write_select_n;
    wire highNib = !high_nibble_write_select_n;

    wire [swlm_pkg::DATA_W-1:0] laneMask;
    genvar lane;
    generate
        for (lane = 0; lane < swlm_pkg::LANES; lane = lane + 1) begin : g_lane
            wire laneUsed = (org == swlm_pkg::ORG_X36)
                || (org == swlm_pkg::ORG_X18 && lane < 2)
                || (org == swlm_pkg::ORG_X9 && lane == 0);
            assign laneMask[lane*swlm_pkg::LANE_W +: swlm_pkg::LANE_W] =
                {swlm_pkg::LANE_W{laneUsed && laneSel[lane]}};
        end
    endgenerate

    wire [swlm_pkg::DATA_W-1:0] nibbleMask = {28'h0000000, {swlm_pkg::NIB_W{highNib}},
        {swlm_pkg::NIB_W{lowNib}}};
    wire [swlm_pkg::DATA_W-1:0] orgMask = (org == swlm_pkg::ORG_X8) ? nibbleMask : laneMask;
    wire [swlm_pkg::DATA_W-1:0] bitEn = writeBeat ? orgMask : 36'h000000000;
    // Read-modify-write keeps deselected lanes unaltered
    wire [swlm_pkg::DATA_W-1:0] nextWord = (wordMem[wordAddr] & ~bitEn)
        | (writeData & bitEn);

    // No reset on the array: contents are undefined until written
    always_ff @(posedge core_clk) begin
        if (clkEnable && writeBeat) begin
            wordMem[wordAddr] <= nextWord;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            accCount <= '0;
            ignCount <= '0;
        end else if (clkEnable) begin
            if (wrStart) begin
                accCount <= accCount + 16'h0001;
            end
            if (wrIgnored) begin
                ignCount <= ignCount + 16'h0001;
            end
        end
    end

    // Bus: zero wait states, stalls only while the clock enable is low
    assign hreadyout = clkEnable;
    assign hresp = 1'b0;
    wire busAccept = hsel && htrans[1] && hready;
    wire regWrite = dataPhaseWrite && clkEnable;

    always_comb begin
        next_org = org;
        next_peekAddr = peekAddr;
        if (regWrite && dataPhaseOffset == swlm_pkg::REG_CTRL) begin
            next_org = swlm_pkg::swlm_org_type'(hwdata[swlm_pkg::CTRL_ORG_LSB +: 2]);
        end else if (regWrite && dataPhaseOffset == swlm_pkg::REG_PEEK_ADDR) begin
            next_peekAddr = hwdata[swlm_pkg::WORD_AW-1:0];
        end
    end

    // Decode reads from next values so a write just before is seen
    always_comb begin
        readMux = 32'h00000000;
        if (haddr[7:0] == swlm_pkg::REG_CTRL) begin
            readMux[swlm_pkg::CTRL_ORG_LSB +: 2] = next_org;
        end else if (haddr[7:0] == swlm_pkg::REG_STATUS) begin
            readMux[swlm_pkg::STAT_ACC_LSB +: swlm_pkg::CNT_W] = accCount;
            readMux[swlm_pkg::STAT_IGN_LSB +: swlm_pkg::CNT_W] = ignCount;
        end else if (haddr[7:0] == swlm_pkg::REG_PEEK_ADDR) begin
            readMux[swlm_pkg::WORD_AW-1:0] = next_peekAddr;
        end else if (haddr[7:0] == swlm_pkg::REG_PEEK_DATA) begin
            readMux = {28'h0000000, 4'h0} | 32'(wordMem[next_peekAddr][31:0]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            org <= swlm_pkg::ORG_RESET;
            peekAddr <= swlm_pkg::PEEK_RESET;
            dataPhaseWrite <= 1'b0;
            dataPhaseOffset <= 8'h00;
            hrdata <= 32'h00000000;
        end else if (clkEnable) begin
            org <= next_org;
            peekAddr <= next_peekAddr;
            // Only whole-word transfers are expected; hsize is not decoded
            dataPhaseWrite <= busAccept && hwrite;
            dataPhaseOffset <= haddr[7:0];
            if (busAccept && !hwrite) begin
                hrdata <= readMux;
            end
        end
    end

    // Checks
    chk_write_spacing: assert property (@(posedge core_clk)
        disable iff (rst || !clkEnable) wrStart |-> ##2 !wrStart)
        else $error("write start accepted on consecutive true edges");

    chk_burst_beats: assert property (@(posedge core_clk)
        disable iff (rst || !clkEnable)
        wrStart |-> ##2 (writeBeat && beatIdx == 2'h0) ##1 (writeBeat && beatIdx == 2'h1)
            ##1 (writeBeat && beatIdx == 2'h2) ##1 (writeBeat && beatIdx == 2'h3))
        else $error("burst data beats out of place");

    chk_burst_address: assert property (@(posedge core_clk)
        disable iff (rst || !clkEnable)
        wrStart |-> ##2 (activeLoc == $past(burstAddr, 2)))
        else $error("burst location not the one latched at start");

    chk_x8_low: assert property (@(posedge core_clk) disable iff (rst)
        (writeBeat && org == swlm_pkg::ORG_X8) |-> bitEn[3:0] == {4{lowNib}})
        else $error("x8 low nibble enable wrong");

    chk_x8_high: assert property (@(posedge core_clk) disable iff (rst)
        (writeBeat && org == swlm_pkg::ORG_X8)
            |-> bitEn[7:4] == {4{highNib}} && bitEn[35:8] == 28'h0000000)
        else $error("x8 high nibble enable wrong");

    chk_x18_lanes: assert property (@(posedge core_clk) disable iff (rst)
        (writeBeat && org == swlm_pkg::ORG_X18) |-> bitEn == {18'h00000,
            {9{laneSel[1]}}, {9{laneSel[0]}}})
        else $error("x18 lane enables wrong");

    chk_x9_single: assert property (@(posedge core_clk) disable iff (rst)
        (writeBeat && org == swlm_pkg::ORG_X9) |-> bitEn == {27'h0000000, {9{laneSel[0]}}})
        else $error("x9 enable wrong");

    chk_x36_full: assert property (@(posedge core_clk) disable iff (rst)
        (writeBeat && org == swlm_pkg::ORG_X36 && laneSel == 4'hf)
            |-> bitEn == 36'hfffffffff)
        else $error("x36 full write not enabled");

    chk_x36_lane0: assert property (@(posedge core_clk) disable iff (rst)
        (writeBeat && org == swlm_pkg::ORG_X36 && laneSel == 4'h1)
            |-> bitEn == 36'h0000001ff)
        else $error("x36 lane 0 alone wrong");

    chk_x36_upper: assert property (@(posedge core_clk) disable iff (rst)
        (writeBeat && org == swlm_pkg::ORG_X36) |-> bitEn[35:9] == {{9{laneSel[3]}},
            {9{laneSel[2]}}, {9{laneSel[1]}}})
        else $error("x36 upper lanes wrong");

    chk_x8_x18_idle: assert property (@(posedge core_clk) disable iff (rst)
        (org == swlm_pkg::ORG_X18 && laneSel[1:0] == 2'h0 || org == swlm_pkg::ORG_X8
            && !lowNib && !highNib) |-> bitEn == 36'h000000000)
        else $error("deselected beat still writes");

    chk_x9_x36_idle: assert property (@(posedge core_clk) disable iff (rst)
        ((org == swlm_pkg::ORG_X9 || org == swlm_pkg::ORG_X36) && laneSel == 4'h0)
            |-> bitEn == 36'h000000000)
        else $error("all-high mask still writes");

    chk_outside_beat: assert property (@(posedge core_clk) disable iff (rst)
        !writeBeat |-> bitEn == 36'h000000000)
        else $error("lane selects act outside write beats");

    chk_lanes_kept: assert property (@(posedge core_clk) disable iff (rst)
        (clkEnable && writeBeat) |=> ((wordMem[$past(wordAddr)] ^ $past(wordMem[wordAddr]))
            & ~$past(bitEn)) == 36'h000000000)
        else $error("deselected bits of the word changed");

    chk_lanes_taken: assert property (@(posedge core_clk) disable iff (rst)
        (clkEnable && writeBeat) |=> ((wordMem[$past(wordAddr)] ^ $past(writeData))
            & $past(bitEn)) == 36'h000000000)
        else $error("selected bits not taken from the beat");

    chk_ignored_count: assert property (@(posedge core_clk) disable iff (rst)
        (clkEnable && wrIgnored) |=> ignCount == $past(ignCount) + 16'h0001)
        else $error("ignored write request not counted");

    chk_frozen_state: assert property (@(posedge core_clk) disable iff (rst)
        !clkEnable |=> $stable(trueEdge) && $stable(startPipe) && $stable(opState))
        else $error("beat state moved while the enable was low");
endmodule : swlm_core

// ===== dv/swlm_ctrl_model.sv
// Memory controller model driving the burst write port
`timescale 1ns/100ps
module swlm_ctrl_model (
    // Clock and beat phase
    input wire logic core_clk,
    input wire logic trueEdge,
    // Write port toward the device
    output logic write_port_select_n,
    output logic read_port_select_n,
    output logic [swlm_pkg::LOC_AW-1:0] burstAddr,
    output logic [swlm_pkg::DATA_W-1:0] writeData,
    output logic [3:0] laneSelN,
    output logic [1:0] nibbleSelN
);
    // Selects stay active between bursts, so stray writes would show
    initial begin
        write_port_select_n = 1'b1;
        read_port_select_n = 1'b1;
        burstAddr = '0;
        writeData = '0;
        laneSelN = 4'h0;
        nibbleSelN = 2'h0;
    end

    task automatic burst(input logic [3:0] loc, input logic [3:0][35:0] d,
        input logic [15:0] m, input logic again);
        do @(negedge core_clk); while (trueEdge !== 1'b1);
        repeat (2) @(posedge core_clk);
        write_port_select_n <= 1'b0;
        burstAddr <= loc;
        @(posedge core_clk);
        // A held select makes a second request two beats later, which is ignored
        write_port_select_n <= !again;
        burstAddr <= ~loc;
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk);
            if (k == 1) write_port_select_n <= 1'b1;
            writeData <= d[k];
            laneSelN <= m[k*4 +: 4];
            nibbleSelN <= m[k*4+2 +: 2];
        end
        @(posedge core_clk);
        writeData <= ~d[3];
        laneSelN <= 4'h0;
        nibbleSelN <= 2'h0;
    endtask : burst
endmodule : swlm_ctrl_model

// ===== dv/sram_write_lane_mask_test.sv
// Self-checking bench for the write lane mask block
`timescale 1ns/100ps
module sram_write_lane_mask_test;
    logic core_clk, rst, clkEnable, hsel, hwrite;
    logic [31:0] haddr, hwdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hreadyout, hresp, trueEdge, wpsN, rpsN;
    wire logic [31:0] hrdata;
    wire logic [3:0] burstAddr, laneSelN;
    wire logic [1:0] nibbleSelN;
    wire logic [35:0] writeData;
    logic [35:0] expMem [64];
    logic [15:0] starts, ignores;
    int miscompares, cmpCount;

    swlm_core u_dut (
        .core_clk(core_clk), .rst(rst), .clkEnable(clkEnable), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .write_port_select_n(wpsN), .read_port_select_n(rpsN),
        .burstAddr(burstAddr), .writeData(writeData),
        .lane0_write_select_n(laneSelN[0]), .lane1_write_select_n(laneSelN[1]),
        .lane2_write_select_n(laneSelN[2]), .lane3_write_select_n(laneSelN[3]),
        .low_nibble_write_select_n(nibbleSelN[0]),
        .high_nibble_write_select_n(nibbleSelN[1]), .trueEdge(trueEdge)
    );

    swlm_ctrl_model u_ctrl (
        .core_clk(core_clk), .trueEdge(trueEdge), .write_port_select_n(wpsN),
        .read_port_select_n(rpsN), .burstAddr(burstAddr), .writeData(writeData),
        .laneSelN(laneSelN), .nibbleSelN(nibbleSelN)
    );

    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] rd;
        ahb(1'b0, a, 32'h0, rd);
        cmpCount++;
        if (rd !== exp || hresp !== 1'b0) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, rd, exp);
        end
    endtask : rdChk

    // Bits outside the organisation never change
    function automatic logic [35:0] merge(swlm_pkg::swlm_org_type org, logic [35:0] old,
        logic [35:0] d, logic [3:0] m);
        logic [35:0] en;
        en = '0;
        case (org)
            swlm_pkg::ORG_X8: en[7:0] = {{4{~m[3]}}, {4{~m[2]}}};
            swlm_pkg::ORG_X9: en[8:0] = {9{~m[0]}};
            swlm_pkg::ORG_X18: en[17:0] = {{9{~m[1]}}, {9{~m[0]}}};
            default: en = {{9{~m[3]}}, {9{~m[2]}}, {9{~m[1]}}, {9{~m[0]}}};
        endcase
        return (old & ~en) | (d & en);
    endfunction : merge

    task automatic wrBurst(input swlm_pkg::swlm_org_type org, input int loc,
        input logic [8:0] salt, input logic [15:0] mk, input logic again);
        logic [3:0][35:0] d;
        logic [31:0] rd;
        ahb(1'b1, swlm_pkg::REG_CTRL, 32'(org), rd);
        for (int k = 0; k < 4; k++) begin
            d[k] = {4{salt ^ 9'(loc * 4 + k)}};
            expMem[loc*4+k] = merge(org, expMem[loc*4+k], d[k], mk[k*4 +: 4]);
        end
        u_ctrl.burst(4'(loc), d, mk, again);
        starts++;
        if (again) ignores++;
        for (int k = 0; k < 4; k++) begin
            ahb(1'b1, swlm_pkg::REG_PEEK_ADDR, 32'(loc * 4 + k), rd);
            rdChk(swlm_pkg::REG_PEEK_DATA, expMem[loc*4+k][31:0], "stored word");
        end
        rdChk(swlm_pkg::REG_STATUS, {ignores, starts}, "start counts");
    endtask : wrBurst

    task wrapUp;
        $display("comparisons %0d miscompares %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrapUp

    initial begin
        logic [31:0] rd;
        rst = 1'b1;
        clkEnable = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        starts = 16'h0;
        ignores = 16'h0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rdChk(swlm_pkg::REG_CTRL, 32'h3, "ctrl reset");
        rdChk(swlm_pkg::REG_STATUS, 32'h0, "status reset");
        rdChk(swlm_pkg::REG_PEEK_ADDR, 32'h0, "peek reset");
        ahb(1'b1, 8'h10, 32'hffffffff, rd);
        rdChk(8'h10, 32'h0, "unmapped");
        for (int l = 0; l < 4; l++) wrBurst(swlm_pkg::ORG_X36, l, 9'h1a5, 16'h0, 1'b0);
        wrBurst(swlm_pkg::ORG_X36, 0, 9'h0f3, 16'h7bde, 1'b0);
        wrBurst(swlm_pkg::ORG_X36, 1, 9'h13c, 16'ha50f, 1'b0);
        wrBurst(swlm_pkg::ORG_X18, 2, 9'h0c9, 16'hc396, 1'b0);
        wrBurst(swlm_pkg::ORG_X9, 3, 9'h166, 16'h1e1e, 1'b0);
        wrBurst(swlm_pkg::ORG_X8, 0, 9'h05a, 16'h3c4b, 1'b0);
        // Mid-run reset with the enable low; counters restart, memory keeps
        rst <= 1'b1;
        clkEnable <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        cmpCount++;
        if (hreadyout !== 1'b0 || trueEdge !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED at %0t: stall or reset state wrong", $time);
        end
        clkEnable <= 1'b1;
        starts = 16'h0;
        ignores = 16'h0;
        rdChk(swlm_pkg::REG_CTRL, 32'h3, "ctrl after reset");
        rdChk(swlm_pkg::REG_STATUS, 32'h0, "status after reset");
        wrBurst(swlm_pkg::ORG_X36, 5, 9'h1e1, 16'h0, 1'b1);
        wrapUp();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #40000;
        miscompares++;
        wrapUp();
    end
endmodule : sram_write_lane_mask_test
